//--- pkg/cbu_pkg.sv
// Shared constants, types and helpers of the conditional branch unit
`default_nettype none
package cbu_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PC_W = 16;
   localparam int K_W = 7;
   localparam int SREG_W = 8;
   localparam int OP_W = 4;
   localparam int SEXT_W = PC_W - K_W;

   // ------------------------------------------------------------
   // Status flag positions
   // ------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ------------------------------------------------------------
   // Reset values and constants
   // ------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
   localparam logic [SREG_W-1:0] SREG_RESET = 8'h00;
   localparam int CYC_NOT_TAKEN = 1;
   localparam int CYC_TAKEN = 2;

   // ------------------------------------------------------------
   // Branch operations of the group
   // ------------------------------------------------------------
   typedef enum logic [OP_W-1:0] {
      CBU_OP_CARRY_CLEAR,
      CBU_OP_SAME_OR_HIGHER,
      CBU_OP_LOWER,
      CBU_OP_MINUS,
      CBU_OP_PLUS,
      CBU_OP_SIGNED_GE,
      CBU_OP_SIGNED_LT,
      CBU_OP_HALF_SET,
      CBU_OP_HALF_CLEAR,
      CBU_OP_TBIT_SET
   } cbu_op_t;

   localparam logic [OP_W-1:0] OP_LAST = 4'h9;

   // Sequencer states
   typedef enum logic [0:0] {
      CBU_ST_IDLE,
      CBU_ST_REFILL
   } cbu_state_t;

   // True for codes that belong to the group
   function automatic logic op_legal(input logic [OP_W-1:0] code);
      return code <= OP_LAST;
   endfunction : op_legal

   // Sign-extend the relative offset to program counter width
   function automatic logic [PC_W-1:0] sext_k(input logic [K_W-1:0] k);
      return {{SEXT_W{k[K_W-1]}}, k};
   endfunction : sext_k

endpackage : cbu_pkg
`default_nettype wire

//--- rtl/cbu_cond_eval.sv
// Flag test of the conditional branch group
`timescale 1ns/1ps
`default_nettype none
module cbu_cond_eval (
   input wire logic [3:0] op_in,   // Branch operation code
   input wire logic [7:0] sreg_in, // Status flags
   output logic cond_out           // Branch condition holds
);

   // ------------------------------------------------------------
   // Condition select
   // ------------------------------------------------------------
   logic c_w;
   logic n_w;
   logic v_w;
   logic h_w;
   logic t_w;

   assign c_w = sreg_in[cbu_pkg::FLAG_C];
   assign n_w = sreg_in[cbu_pkg::FLAG_N];
   assign v_w = sreg_in[cbu_pkg::FLAG_V];
   assign h_w = sreg_in[cbu_pkg::FLAG_H];
   assign t_w = sreg_in[cbu_pkg::FLAG_T];

   // Illegal codes never branch, so a stray code cannot redirect fetch
   always_comb begin
      cond_out = 1'b0;
      unique case (cbu_pkg::cbu_op_t'(op_in))
         cbu_pkg::CBU_OP_CARRY_CLEAR: cond_out = ~c_w;
         cbu_pkg::CBU_OP_SAME_OR_HIGHER: cond_out = ~c_w;
         cbu_pkg::CBU_OP_LOWER: cond_out = c_w;
         cbu_pkg::CBU_OP_MINUS: cond_out = n_w;
         cbu_pkg::CBU_OP_PLUS: cond_out = ~n_w;
         cbu_pkg::CBU_OP_SIGNED_GE: cond_out = ~(n_w ^ v_w);
         cbu_pkg::CBU_OP_SIGNED_LT: cond_out = n_w ^ v_w;
         cbu_pkg::CBU_OP_HALF_SET: cond_out = h_w;
         cbu_pkg::CBU_OP_HALF_CLEAR: cond_out = ~h_w;
         cbu_pkg::CBU_OP_TBIT_SET: cond_out = t_w;
         default: cond_out = 1'b0;
      endcase
   end

endmodule : cbu_cond_eval
`default_nettype wire

//--- rtl/cbu_target_adder.sv
// Branch target and fall-through address arithmetic
`timescale 1ns/1ps
`default_nettype none
module cbu_target_adder (
   input wire logic [15:0] pc_in,   // Program counter of the branch
   input wire logic [6:0] k_in,     // Signed word offset
   output logic [15:0] target_out,  // Taken address
   output logic [15:0] seq_out      // Fall-through address
);

   // ------------------------------------------------------------
   // Address sums
   // ------------------------------------------------------------
   // Wraps modulo the address space, as the fetch stage does
   assign target_out = pc_in + cbu_pkg::sext_k(k_in)
                       + cbu_pkg::PC_STEP;
   assign seq_out = pc_in + cbu_pkg::PC_STEP;

endmodule : cbu_target_adder
`default_nettype wire

//--- rtl/cbu_branch_unit.sv
// Conditional branch unit: decode, flag test and program counter update
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit (
   input wire logic clk_sys_in,       // Core clock, 50 MHz
   input wire logic rst_n_in,         // Synchronous reset, active low
   input wire logic req_valid_in,     // Branch instruction offered
   input wire logic [3:0] op_in,      // Branch operation code
   input wire logic [6:0] k_in,       // Signed word offset
   input wire logic [15:0] pc_in,     // Program counter of the branch
   input wire logic [7:0] sreg_in,    // Status flags from the core
   output logic req_ready_out,        // Unit can take an instruction
   output logic pc_load_out,          // Refill fetch from next_pc_out
   output logic [15:0] next_pc_out,   // Next program counter
   output logic done_out,             // Instruction completes
   output logic taken_out,            // Completed branch was taken
   output logic illegal_out,          // Code outside the group seen
   output logic [7:0] flags_out       // Status flags, never altered
);

   // ------------------------------------------------------------
   // Decode and arithmetic
   // ------------------------------------------------------------
   logic cond_w;
   logic legal_w;
   logic accept_w;
   logic [15:0] target_w;
   logic [15:0] seq_w;

   cbu_cond_eval u_cond (
      .op_in(op_in),
      .sreg_in(sreg_in),
      .cond_out(cond_w)
   );

   cbu_target_adder u_add (
      .pc_in(pc_in),
      .k_in(k_in),
      .target_out(target_w),
      .seq_out(seq_w)
   );

   // Request is taken only while idle
   assign legal_w = cbu_pkg::op_legal(op_in);
   assign accept_w = req_valid_in && req_ready_out;

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   cbu_pkg::cbu_state_t state_q;
   cbu_pkg::cbu_state_t state_d;
   logic pc_load_q;
   logic pc_load_d;
   logic [15:0] next_pc_q;
   logic [15:0] next_pc_d;
   logic done_q;
   logic done_d;
   logic taken_q;
   logic taken_d;
   logic illegal_q;
   logic illegal_d;
   logic [7:0] flags_q;
   logic [7:0] flags_d;

   // Next state: a taken branch holds the unit for one refill cycle
   always_comb begin
      state_d = state_q;
      pc_load_d = 1'b0;
      next_pc_d = next_pc_q;
      done_d = 1'b0;
      taken_d = 1'b0;
      illegal_d = 1'b0;
      flags_d = flags_q;
      unique case (state_q)
         cbu_pkg::CBU_ST_IDLE: begin
            if (accept_w && !legal_w) begin
               illegal_d = 1'b1;
            end else if (accept_w && cond_w) begin
               next_pc_d = target_w;
               pc_load_d = 1'b1;
               flags_d = sreg_in;
               state_d = cbu_pkg::CBU_ST_REFILL;
            end else if (accept_w) begin
               next_pc_d = seq_w;
               flags_d = sreg_in;
               done_d = 1'b1;
            end
         end
         cbu_pkg::CBU_ST_REFILL: begin
            // Second cycle: fetch restarts from the target
            done_d = 1'b1;
            taken_d = 1'b1;
            state_d = cbu_pkg::CBU_ST_IDLE;
         end
      endcase
   end

   // Registers of the sequencer
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_q <= cbu_pkg::CBU_ST_IDLE;
         pc_load_q <= 1'b0;
         next_pc_q <= cbu_pkg::PC_RESET;
         done_q <= 1'b0;
         taken_q <= 1'b0;
         illegal_q <= 1'b0;
         flags_q <= cbu_pkg::SREG_RESET;
      end else begin
         state_q <= state_d;
         pc_load_q <= pc_load_d;
         next_pc_q <= next_pc_d;
         done_q <= done_d;
         taken_q <= taken_d;
         illegal_q <= illegal_d;
         flags_q <= flags_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Ready is combinational so a not-taken branch may follow at once
   assign req_ready_out = (state_q == cbu_pkg::CBU_ST_IDLE);
   assign pc_load_out = pc_load_q;
   assign next_pc_out = next_pc_q;
   assign done_out = done_q;
   assign taken_out = taken_q;
   assign illegal_out = illegal_q;
   assign flags_out = flags_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb_a @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   // Independent model of the target address for the checks
   logic [15:0] exp_target_w;
   assign exp_target_w = pc_in + {{9{k_in[6]}}, k_in} + 16'h0001;

   // Instruction cycle counter, counts cycles since acceptance
   logic [1:0] cyc_q;
   logic [1:0] cyc_d;
   always_comb begin
      cyc_d = cyc_q;
      if (accept_w && legal_w) begin
         cyc_d = 2'h1;
      end else if (cyc_q != 2'h0 && cyc_q != 2'h3) begin
         cyc_d = cyc_q + 2'h1;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cyc_q <= 2'h0;
      end else begin
         cyc_q <= cyc_d;
      end
   end

   carry_clear_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_CARRY_CLEAR
      |=> pc_load_out == !$past(sreg_in[cbu_pkg::FLAG_C]))
      else $error("carry clear branch decision wrong");

   same_higher_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_SAME_OR_HIGHER
      |=> pc_load_out == !$past(sreg_in[cbu_pkg::FLAG_C]))
      else $error("same or higher branch decision wrong");

   lower_cond_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_LOWER
      |=> pc_load_out == $past(sreg_in[cbu_pkg::FLAG_C]))
      else $error("lower branch decision wrong");

   minus_cond_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_MINUS
      |=> pc_load_out == $past(sreg_in[cbu_pkg::FLAG_N]))
      else $error("minus branch decision wrong");

   plus_cond_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_PLUS
      |=> pc_load_out == !$past(sreg_in[cbu_pkg::FLAG_N]))
      else $error("plus branch decision wrong");

   signed_ge_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_SIGNED_GE
      |=> pc_load_out == !$past(sreg_in[cbu_pkg::FLAG_N]
          ^ sreg_in[cbu_pkg::FLAG_V]))
      else $error("signed ge branch decision wrong");

   signed_lt_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_SIGNED_LT
      |=> pc_load_out == $past(sreg_in[cbu_pkg::FLAG_N]
          ^ sreg_in[cbu_pkg::FLAG_V]))
      else $error("signed lt branch decision wrong");

   half_set_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_HALF_SET
      |=> pc_load_out == $past(sreg_in[cbu_pkg::FLAG_H]))
      else $error("half carry set branch decision wrong");

   half_clear_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_HALF_CLEAR
      |=> pc_load_out == !$past(sreg_in[cbu_pkg::FLAG_H]))
      else $error("half carry clear branch decision wrong");

   tbit_set_a: assert property (
      accept_w && op_in == cbu_pkg::CBU_OP_TBIT_SET
      |=> pc_load_out == $past(sreg_in[cbu_pkg::FLAG_T]))
      else $error("transfer bit branch decision wrong");

   taken_target_a: assert property (
      accept_w && legal_w && cond_w
      |=> next_pc_out == $past(exp_target_w)
          ##1 next_pc_out == $past(exp_target_w, 2) && done_out)
      else $error("taken target address wrong");

   fall_through_a: assert property (
      accept_w && legal_w && !cond_w
      |=> next_pc_out == $past(pc_in) + 16'h0001)
      else $error("fall-through address wrong");

   flags_kept_a: assert property (
      accept_w && legal_w
      |=> flags_out == $past(sreg_in))
      else $error("status flags changed by branch");

   flags_refill_a: assert property (
      state_q == cbu_pkg::CBU_ST_REFILL |=> $stable(flags_out))
      else $error("status flags changed during refill");

   one_cycle_a: assert property (
      accept_w && legal_w && !cond_w
      |=> done_out && !taken_out && !pc_load_out && req_ready_out
          && cyc_q == 2'(cbu_pkg::CYC_NOT_TAKEN))
      else $error("not-taken branch not done in one cycle");

   two_cycle_a: assert property (
      accept_w && legal_w && cond_w
      |=> (!done_out && pc_load_out && !req_ready_out)
          ##1 (done_out && taken_out && req_ready_out
               && cyc_q == 2'(cbu_pkg::CYC_TAKEN)))
      else $error("taken branch not done in two cycles");

   illegal_drop_a: assert property (
      accept_w && !legal_w
      |=> illegal_out && !done_out && !pc_load_out)
      else $error("illegal code not rejected");

   // Fetch must never see the counter move without a legal accept
   hold_idle_a: assert property (
      state_q == cbu_pkg::CBU_ST_IDLE && !(accept_w && legal_w)
      |=> $stable(next_pc_out) && $stable(flags_out))
      else $error("outputs changed without an accepted branch");

   pulse_excl_a: assert property (
      !(pc_load_out && done_out) && !(illegal_out && done_out))
      else $error("completion pulses overlap");

   refill_once_a: assert property (
      state_q == cbu_pkg::CBU_ST_REFILL |=> req_ready_out)
      else $error("refill lasts more than one cycle");

   taken_pulse_a: assert property (
      taken_out |-> done_out && $past(pc_load_out))
      else $error("taken reported without a refill");

   // Checked through reset, so the default disable is overridden
   reset_quiet_a: assert property (
      disable iff (1'b0)
      !rst_n_in |=> !pc_load_out && !done_out && !taken_out && !illegal_out)
      else $error("pulses not cleared by reset");

   // ------------------------------------------------------------
   // Scenario coverage
   // ------------------------------------------------------------
   not_taken_c: cover property (
      accept_w && legal_w && !cond_w ##1 done_out);

   taken_c: cover property (
      accept_w && legal_w && cond_w ##1 pc_load_out ##1 taken_out);

   back_to_back_c: cover property (
      accept_w && legal_w && !cond_w ##1 accept_w && legal_w);

   signed_taken_c: cover property (
      accept_w && op_in == cbu_pkg::CBU_OP_SIGNED_LT && cond_w);

   illegal_c: cover property (accept_w && !legal_w);

endmodule : cbu_branch_unit
`default_nettype wire

//--- verification/tb.sv
// Self-checking testbench of the conditional branch unit
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module tb;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic req_valid_in = 1'b0;
   logic [3:0] op_in = 4'h0;
   logic [6:0] k_in = 7'h00;
   logic [15:0] pc_in = 16'h0000;
   logic [7:0] sreg_in = 8'h00;
   logic req_ready_out, pc_load_out, done_out, taken_out, illegal_out;
   logic [15:0] next_pc_out;
   logic [7:0] flags_out;
   int err_count = 0;
   int n_tests = 0;

   // 50 MHz core clock
   always #10 clk_sys_in = ~clk_sys_in;

   cbu_branch_unit cbu_branch_unit_inst (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .req_valid_in(req_valid_in),
      .op_in(op_in),
      .k_in(k_in),
      .pc_in(pc_in),
      .sreg_in(sreg_in),
      .req_ready_out(req_ready_out),
      .pc_load_out(pc_load_out),
      .next_pc_out(next_pc_out),
      .done_out(done_out),
      .taken_out(taken_out),
      .illegal_out(illegal_out),
      .flags_out(flags_out)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic stop_test();
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // Expected condition, worked out from the flag definitions
   function automatic logic cond_exp(input logic [3:0] op,
                                     input logic [7:0] s);
      case (op)
         4'h0, 4'h1: return !s[cbu_pkg::FLAG_C];
         4'h2: return s[cbu_pkg::FLAG_C];
         4'h3: return s[cbu_pkg::FLAG_N];
         4'h4: return !s[cbu_pkg::FLAG_N];
         4'h5: return !(s[cbu_pkg::FLAG_N] ^ s[cbu_pkg::FLAG_V]);
         4'h6: return s[cbu_pkg::FLAG_N] ^ s[cbu_pkg::FLAG_V];
         4'h7: return s[cbu_pkg::FLAG_H];
         4'h8: return !s[cbu_pkg::FLAG_H];
         default: return s[cbu_pkg::FLAG_T];
      endcase
   endfunction : cond_exp

   // Bounded wait so a stuck refill state cannot hang the run
   task automatic wait_ready();
      int n;
      for (n = 0; n < 20 && req_ready_out !== 1'b1; n++) begin
         @(posedge clk_sys_in);
         #1;
      end
      if (req_ready_out !== 1'b1) begin
         err_count++;
         stop_test();
      end
   endtask : wait_ready

   // One branch request, judged cycle by cycle against the walk
   task automatic run_branch(input logic [3:0] op, input logic [6:0] k,
                             input logic [15:0] pc, input logic [7:0] sr);
      logic tk;
      logic [15:0] tgt;
      tk = cond_exp(op, sr);
      tgt = tk ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
      wait_ready();
      @(posedge clk_sys_in);
      req_valid_in <= 1'b1;
      op_in <= op;
      k_in <= k;
      pc_in <= pc;
      sreg_in <= sr;
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      #1;
      `CHK(pc_load_out, tk)
      `CHK(done_out, !tk)
      `CHK(next_pc_out, tgt)
      `CHK(flags_out, sr)
      if (tk) begin
         `CHK(req_ready_out, 1'b0)
         @(posedge clk_sys_in);
         #1;
         `CHK(done_out, 1'b1)
         `CHK(taken_out, 1'b1)
         `CHK(pc_load_out, 1'b0)
         `CHK(req_ready_out, 1'b1)
      end else begin
         `CHK(taken_out, 1'b0)
         `CHK(req_ready_out, 1'b1)
      end
   endtask : run_branch

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      repeat (8) @(posedge clk_sys_in);
      #1;
      `CHK(done_out, 1'b0)
      `CHK(pc_load_out, 1'b0)
      `CHK(next_pc_out, cbu_pkg::PC_RESET)
      `CHK(flags_out, cbu_pkg::SREG_RESET)
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
   endtask : t_reset

   // Every code against flag patterns that make each test true and false
   task automatic t_conditions();
      logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h04, 8'h69};
      for (int i = 0; i < 10; i++) begin
         for (int j = 0; j < 4; j++) begin
            run_branch(i[3:0], 7'(i * 5 + j), 16'(i * 256 + j * 16), pat[j]);
         end
      end
   endtask : t_conditions

   // Extreme offsets and wrap of the target
   task automatic t_offsets();
      run_branch(4'h7, 7'h01, 16'hffff, 8'h20);
      run_branch(4'h9, 7'h40, 16'h0010, 8'h40);
      run_branch(4'h3, 7'h3f, 16'hffc0, 8'h04);
   endtask : t_offsets

   // Two fall-through requests on consecutive edges
   task automatic t_back_to_back();
      wait_ready();
      @(posedge clk_sys_in);
      req_valid_in <= 1'b1;
      op_in <= 4'h4;
      pc_in <= 16'h1234;
      sreg_in <= 8'h04;
      @(posedge clk_sys_in);
      op_in <= 4'h3;
      pc_in <= 16'h2000;
      sreg_in <= 8'h80;
      #1;
      `CHK(done_out, 1'b1)
      `CHK(next_pc_out, 16'h1235)
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      #1;
      `CHK(done_out, 1'b1)
      `CHK(next_pc_out, 16'h2001)
      `CHK(flags_out, 8'h80)
   endtask : t_back_to_back

   // A request held through the refill cycle must be ignored
   task automatic t_refill_ignored();
      wait_ready();
      @(posedge clk_sys_in);
      req_valid_in <= 1'b1;
      op_in <= 4'h2;
      k_in <= 7'h10;
      pc_in <= 16'h0100;
      sreg_in <= 8'h01;
      @(posedge clk_sys_in);
      pc_in <= 16'h0500;
      sreg_in <= 8'h00;
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      #1;
      `CHK(taken_out, 1'b1)
      @(posedge clk_sys_in);
      #1;
      `CHK(done_out, 1'b0)
      `CHK(next_pc_out, 16'h0111)
      `CHK(flags_out, 8'h01)
   endtask : t_refill_ignored

   // Codes outside the group leave the program counter and flags alone
   task automatic t_illegal();
      wait_ready();
      @(posedge clk_sys_in);
      req_valid_in <= 1'b1;
      op_in <= 4'hf;
      pc_in <= 16'h7777;
      sreg_in <= 8'hff;
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      #1;
      `CHK(illegal_out, 1'b1)
      `CHK(done_out, 1'b0)
      `CHK(pc_load_out, 1'b0)
      `CHK(next_pc_out, 16'h0111)
      `CHK(flags_out, 8'h01)
      @(posedge clk_sys_in);
      #1;
      `CHK(illegal_out, 1'b0)
   endtask : t_illegal

   // Reset in the refill cycle drops the pending completion
   task automatic t_mid_reset();
      wait_ready();
      @(posedge clk_sys_in);
      req_valid_in <= 1'b1;
      op_in <= 4'h6;
      k_in <= 7'h02;
      pc_in <= 16'h0040;
      sreg_in <= 8'h04;
      @(posedge clk_sys_in);
      req_valid_in <= 1'b0;
      rst_n_in <= 1'b0;
      #1;
      `CHK(pc_load_out, 1'b1)
      @(posedge clk_sys_in);
      #1;
      `CHK(done_out, 1'b0)
      `CHK(taken_out, 1'b0)
      `CHK(next_pc_out, cbu_pkg::PC_RESET)
      `CHK(req_ready_out, 1'b1)
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      run_branch(4'h5, 7'h7f, 16'h0300, 8'h00);
   endtask : t_mid_reset

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      t_reset();
      t_conditions();
      t_offsets();
      t_back_to_back();
      t_refill_ignored();
      t_illegal();
      t_mid_reset();
      stop_test();
   end
endmodule : tb
`default_nettype wire
